// [verilog/rqr_queue.sv]
// Purpose: Host read port of the shared receive queue with RAM test mode.
// Assumes: Host bus, receiver and control bits all on sys_clk.
// Notes: Token is written in front of its block once the count is known.
// Function
// - Data read only at one address, bursts allowed.
// - Head flag set when head holds a token.
// - Token bits 0-6 reserved; snooped ack else zero.
// - Token bit 11 marks packet completion.
// - Token bit 12 mirrors snoop enable.
// - Token bits 13-14 hold receive speed.
// - Token bits 15-23 hold block quadlet count.
// - Token bits 24-27 tcode, special code forced.
// - Token bits 28-31 hold ack, zero for some.
// - Trigger size gives one event per block.
// - Trigger needs enable, no bad header, size>5.
// - Short and special packets never split.
// - Test mode pauses queue and freezes status.
// - Test access uses counter, then counter increments.
// - RAM is 512 by 33, top bit control.
// - Test write stores data plus control value.
// - Test read compares control bit, sets mismatch.
// - Host may load the test address counter.
// - Address clear zeroes counter, mismatch, self-clears.
// - Test mode head flag shows addressed control bit.
// - Receive region starts after both transmit regions.
module rqr_queue (
  input wire logic sys_clk,
  input wire logic rst_n,
  // Host bus: one quadlet per cycle while selected.
  input wire logic host_sel,
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [31:0] host_wdata,
  output logic [31:0] host_rdata,
  output logic host_ack,
  // Receiver stream into the staging FIFO.
  input wire logic rx_valid,
  output logic rx_ready,
  input wire rqr_pkg::rqr_item_t rx_item,
  // Control bits held elsewhere in the device.
  input wire logic snoop_enable,
  input wire logic block_trigger_enable,
  input wire logic bad_header_receive_option,
  input wire logic [7:0] trigger_size,
  input wire logic [8:0] async_queue_size,
  input wire logic [8:0] iso_queue_size,
  input wire logic memory_test_enable,
  input wire logic test_control_value,
  input wire logic test_address_clear_set,
  input wire logic test_addr_load,
  input wire logic [8:0] test_addr_value,
  // Status shown to software.
  output logic receive_data_ready_irq,
  output logic token_at_head_flag,
  output logic packet_complete_flag,
  output logic [8:0] status_quadlet_count,
  output logic [9:0] queue_used_count,
  output logic control_mismatch_flag,
  output logic test_address_clear_alias,
  output logic [8:0] test_addr_count
);

  // Writer states.
  typedef enum logic [1:0] {
    RQR_W_DATA = 2'b01,
    RQR_W_TOKEN = 2'b10
  } rqr_wstate_t;

  // Shared RAM behind all three queues.
  logic [32:0] ram [rqr_pkg::RQR_RAM_DEPTH];
  // Receive region base and size.
  logic [9:0] base;
  logic [9:0] size;
  // Committed read and write offsets within the region.
  logic [8:0] rd_off_reg;
  logic [8:0] blk_off_reg;
  logic [8:0] dat_off_reg;
  // Data quadlets written in the current block.
  logic [8:0] blk_cnt_reg;
  // Information and last flag of the block being built.
  rqr_pkg::rqr_pkt_info_t info_reg;
  logic last_reg;
  rqr_wstate_t wstate_reg;
  // Staging FIFO output side.
  logic st_valid;
  logic st_ready;
  rqr_pkg::rqr_item_t st_item;
  // Host access decode.
  logic data_hit;
  logic norm_rd;
  logic test_rd;
  logic test_wr;
  // Writer helpers.
  logic trig_active;
  logic blk_end;
  logic pop;
  logic [9:0] room_need;
  logic [31:0] token;
  // Head entry views.
  logic [8:0] rd_addr;
  logic [32:0] head_word;
  logic [32:0] test_word;
  logic head_tok;

  // The receive region follows both transmit regions.
  assign base = 10'(async_queue_size) + 10'(iso_queue_size);
  assign size = 10'(rqr_pkg::RQR_RAM_DEPTH) - base;

  // Staging FIFO in the data path; its ready stalls the receiver.
  rqr_fifo #(
    .WIDTH(rqr_pkg::RQR_ITEM_W),
    .DEPTH(rqr_pkg::RQR_STAGE_DEPTH)
  ) u_stage (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_item),
    .out_valid(st_valid),
    .out_ready(st_ready),
    .out_data(st_item)
  );

  // Only the data address answers; other addresses belong elsewhere.
  assign data_hit = host_sel &&
                    (host_addr == rqr_pkg::RQR_DATA_ADDR);
  assign norm_rd = data_hit && !host_wr && !memory_test_enable;
  assign test_rd = data_hit && !host_wr && memory_test_enable;
  assign test_wr = data_hit && host_wr && memory_test_enable;

  // Splitting into trigger-size blocks needs all three conditions.
  assign trig_active = block_trigger_enable &&
                       !bad_header_receive_option &&
                       (trigger_size > rqr_pkg::RQR_TRIG_MIN);

  // A block ends at packet end or when the trigger size is reached.
  // Short and special packets always stay in one block.
  assign blk_end = st_item.last ||
                   (trig_active && !st_item.info.no_split_pkt &&
                    !st_item.info.special_pkt &&
                    (10'(blk_cnt_reg) + 10'h001 ==
                     10'(trigger_size)));

  // Room for this quadlet plus the token slot kept ahead of it.
  assign room_need = queue_used_count + 10'(blk_cnt_reg) + 10'h002;

  // Writer drains the staging FIFO only outside test mode.
  assign pop = (wstate_reg == RQR_W_DATA) && st_valid &&
               !memory_test_enable && (room_need <= size);
  assign st_ready = pop;

  // Token assembly from the latched packet information.
  always_comb begin
    token = '0;
    if (snoop_enable) begin
      token[rqr_pkg::RQR_TOK_ACKSNP_LSB +: 4] =
        info_reg.snooped_ack_code;
    end
    token[rqr_pkg::RQR_TOK_PAC_BIT] = last_reg;
    token[rqr_pkg::RQR_TOK_SNP_BIT] = snoop_enable;
    token[rqr_pkg::RQR_TOK_SPD_LSB +: 2] =
      info_reg.receive_speed_code;
    token[rqr_pkg::RQR_TOK_CNT_LSB +: 9] = blk_cnt_reg;
    if (info_reg.special_pkt) begin
      token[rqr_pkg::RQR_TOK_TCODE_LSB +: 4] =
        rqr_pkg::RQR_TCODE_SPECIAL;
    end else begin
      token[rqr_pkg::RQR_TOK_TCODE_LSB +: 4] = info_reg.tcode;
    end
    // Ack holds what was sent when the packet completes here.
    if (last_reg && !info_reg.no_ack_pkt) begin
      token[rqr_pkg::RQR_TOK_ACK_LSB +: 4] =
        info_reg.ack_sent;
    end
  end

  // Region offsets wrap at the end of the receive region.
  function automatic logic [8:0] off_inc(input logic [8:0] off,
                                         input logic [9:0] sz);
    logic [9:0] nxt;
    nxt = 10'(off) + 10'h001;
    off_inc = (nxt >= sz) ? 9'h000 : nxt[8:0];
  endfunction

  // Absolute RAM address of a region offset.
  function automatic logic [8:0] off_addr(input logic [8:0] off,
                                          input logic [9:0] b);
    logic [9:0] sum;
    sum = b + 10'(off);
    off_addr = sum[8:0];
  endfunction

  assign rd_addr = off_addr(rd_off_reg, base);
  assign head_word = ram[rd_addr];
  assign test_word = ram[test_addr_count];
  // A token is the only entry with the control bit set.
  assign head_tok = (queue_used_count != '0) &&
                    head_word[rqr_pkg::RQR_CTRL_BIT];

  // RAM writes: receive data, tokens, and host test writes.
  always_ff @(posedge sys_clk) begin
    if (test_wr) begin
      ram[test_addr_count] <= {test_control_value,
                               host_wdata};
    end else if (pop) begin
      ram[off_addr(dat_off_reg, base)] <= {1'b0, st_item.data};
    end else if (wstate_reg == RQR_W_TOKEN) begin
      ram[off_addr(blk_off_reg, base)] <= {1'b1, token};
    end
  end

  // Writer state machine: fill data, then place the token.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wstate_reg <= RQR_W_DATA;
    end else begin
      case (wstate_reg)
        RQR_W_DATA: begin
          if (pop && blk_end) begin
            wstate_reg <= RQR_W_TOKEN;
          end
        end
        RQR_W_TOKEN: begin
          wstate_reg <= RQR_W_DATA;
        end
        default: begin
          wstate_reg <= RQR_W_DATA;
        end
      endcase
    end
  end

  // Block bookkeeping: count, packet info and last flag.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blk_cnt_reg <= '0;
      info_reg <= '0;
      last_reg <= 1'b0;
    end else if (pop) begin
      blk_cnt_reg <= blk_cnt_reg + 9'h001;
      info_reg <= st_item.info;
      last_reg <= st_item.last;
    end else if (wstate_reg == RQR_W_TOKEN) begin
      blk_cnt_reg <= '0;
    end
  end

  // Write offsets: the data runs one slot ahead of the token slot.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blk_off_reg <= '0;
      dat_off_reg <= 9'h001;
    end else if (pop) begin
      dat_off_reg <= off_inc(dat_off_reg, size);
    end else if (wstate_reg == RQR_W_TOKEN) begin
      // Next token slot is where data stopped.
      blk_off_reg <= dat_off_reg;
      dat_off_reg <= off_inc(dat_off_reg, size);
    end
  end

  // One ready event per committed block.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_data_ready_irq <= 1'b0;
    end else begin
      receive_data_ready_irq <= (wstate_reg == RQR_W_TOKEN);
    end
  end

  // Read offset moves by one per normal read of a non-empty queue.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_off_reg <= '0;
    end else if (norm_rd && (queue_used_count != '0)) begin
      rd_off_reg <= off_inc(rd_off_reg, size);
    end
  end

  // Committed occupancy: a block counts only once its token is in.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      queue_used_count <= '0;
    end else begin
      queue_used_count <= queue_used_count
        + ((wstate_reg == RQR_W_TOKEN) ? 10'(blk_cnt_reg) + 10'h001
                                        : 10'h000)
        - ((norm_rd && (queue_used_count != '0)) ? 10'h001
                                                  : 10'h000);
    end
  end

  // Host read data and acknowledge, one cycle after the access.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata <= '0;
      host_ack <= 1'b0;
    end else begin
      host_ack <= data_hit;
      if (test_rd) begin
        host_rdata <= test_word[31:0];
      end else if (norm_rd && (queue_used_count != '0)) begin
        host_rdata <= head_word[31:0];
      end else begin
        // Empty queue reads return zero rather than stale data.
        host_rdata <= '0;
      end
    end
  end

  // Head status; frozen while the RAM is under test.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      packet_complete_flag <= 1'b0;
      status_quadlet_count <= '0;
    end else if (!memory_test_enable) begin
      packet_complete_flag <= head_tok &&
        head_word[rqr_pkg::RQR_TOK_PAC_BIT];
      status_quadlet_count <= head_tok ?
        head_word[rqr_pkg::RQR_TOK_CNT_LSB +: 9] : 9'h000;
    end
  end

  // Head flag; in test mode it shows the addressed control bit.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      token_at_head_flag <= 1'b0;
    end else if (memory_test_enable) begin
      token_at_head_flag <=
        test_word[rqr_pkg::RQR_CTRL_BIT];
    end else begin
      token_at_head_flag <= head_tok;
    end
  end

  // Clear bit: set by software, acts once, then drops by itself.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      test_address_clear_alias <= 1'b0;
    end else begin
      test_address_clear_alias <= test_address_clear_set &&
        !test_address_clear_alias;
    end
  end

  // Test address counter: clear, load, or step after each access.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      test_addr_count <= '0;
    end else if (test_address_clear_alias) begin
      test_addr_count <= '0;
    end else if (test_addr_load) begin
      test_addr_count <= test_addr_value;
    end else if (test_rd || test_wr) begin
      test_addr_count <= test_addr_count + 9'h001;
    end
  end

  // Mismatch flag: a failing compare wins over a clear.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_mismatch_flag <= 1'b0;
    end else if (test_rd && (test_word[rqr_pkg::RQR_CTRL_BIT] !=
                             test_control_value)) begin
      control_mismatch_flag <= 1'b1;
    end else if (test_address_clear_alias) begin
      control_mismatch_flag <= 1'b0;
    end
  end

endmodule

// [verilog/rqr_pkg.sv]
// Purpose: Shared constants and types of the receive queue read port.
// Assumes: One 100 MHz clock; host reads quadlets at one data address.
// Notes: Token fields are given as LSB-based bit positions.
package rqr_pkg;

  // Host address of the receive queue data port.
  localparam logic [7:0] RQR_DATA_ADDR = 8'hc0;

  // Shared RAM geometry: 512 entries of 33 bits.
  localparam int RQR_RAM_DEPTH = 512;
  localparam int RQR_AW = 9;
  localparam int RQR_RAM_W = 33;
  localparam int RQR_CTRL_BIT = 32;

  // Staging FIFO depth in front of the RAM writer.
  localparam int RQR_STAGE_DEPTH = 16;

  // Token field positions, LSB numbering.
  localparam int RQR_TOK_ACK_LSB = 0;
  localparam int RQR_TOK_TCODE_LSB = 4;
  localparam int RQR_TOK_CNT_LSB = 8;
  localparam int RQR_TOK_SPD_LSB = 17;
  localparam int RQR_TOK_SNP_BIT = 19;
  localparam int RQR_TOK_PAC_BIT = 20;
  localparam int RQR_TOK_ACKSNP_LSB = 21;

  // Fixed code that marks self-ID, configuration and link-on packets.
  localparam logic [3:0] RQR_TCODE_SPECIAL = 4'he;
  // Largest trigger size that is still too small to enable splitting.
  localparam logic [7:0] RQR_TRIG_MIN = 8'h05;

  // Receive speed codes.
  typedef enum logic [1:0] {
    RQR_SPD_100 = 2'h0,
    RQR_SPD_200 = 2'h1,
    RQR_SPD_400 = 2'h2
  } rqr_speed_t;

  // Per-packet information supplied by the receiver.
  typedef struct packed {
    logic [3:0] snooped_ack_code;
    logic [3:0] ack_sent;
    rqr_speed_t receive_speed_code;
    logic [3:0] tcode;
    logic special_pkt;
    logic no_ack_pkt;
    logic no_split_pkt;
  } rqr_pkt_info_t;

  // One received quadlet with its packet information.
  typedef struct packed {
    rqr_pkt_info_t info;
    logic last;
    logic [31:0] data;
  } rqr_item_t;

  localparam int RQR_ITEM_W = $bits(rqr_item_t);

endpackage

// [verilog/rqr_fifo.sv]
// Purpose: Small valid/ready FIFO with parameter width and depth.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: Full and empty come straight from an occupancy counter.
module rqr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  // Storage, pointers and occupancy.
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] cnt_reg;
  logic push;
  logic pop;

  // Ready only while a free slot exists, so the source really stalls.
  assign in_ready = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr_reg];

  // Storage writes carry no reset.
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointer and counter upkeep.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

endmodule

// [testbench/rqr_queue_asserts.sv]
// Purpose: Port-level checks of the receive queue read port.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes: Clear may land one or two cycles after it is requested.
module rqr_queue_asserts (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic host_sel,
  input wire logic [7:0] host_addr,
  input wire logic host_ack,
  input wire logic memory_test_enable,
  input wire logic test_address_clear_set,
  input wire logic test_addr_load,
  input wire logic [8:0] test_addr_value,
  input wire logic receive_data_ready_irq,
  input wire logic [8:0] status_quadlet_count,
  input wire logic [9:0] queue_used_count,
  input wire logic control_mismatch_flag,
  input wire logic test_address_clear_alias,
  input wire logic [8:0] test_addr_count
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // True when a host cycle is aimed at the data port.
  logic hit;
  assign hit = host_sel && (host_addr == rqr_pkg::RQR_DATA_ADDR);
  a_ack_on_access: assert property (hit |=> host_ack)
    else $error("data port access not acknowledged");
  a_no_stray_ack: assert property (!hit |=> !host_ack)
    else $error("acknowledge without a data port access");
  a_irq_one_pulse: assert property (
    receive_data_ready_irq |=> !receive_data_ready_irq)
    else $error("data ready event longer than one cycle");
  a_alias_self_clear: assert property (
    test_address_clear_alias |=> !test_address_clear_alias)
    else $error("clear alias did not return to zero");
  a_clear_zeroes: assert property (
    test_address_clear_set && !host_sel && !test_addr_load |->
    ##[1:2] (test_addr_count == 9'h0))
    else $error("test address not cleared");
  a_test_step: assert property (memory_test_enable && hit &&
    !test_addr_load && !test_address_clear_set &&
    !$past(test_address_clear_set) |=>
    test_addr_count == $past(test_addr_count) + 9'h1)
    else $error("test address did not advance by one");
  a_addr_load: assert property (test_addr_load &&
    !test_address_clear_set && !$past(test_address_clear_set) |=>
    test_addr_count == $past(test_addr_value))
    else $error("test address load not taken");
  a_status_frozen: assert property (memory_test_enable &&
    $past(memory_test_enable, 2) |-> $stable(queue_used_count) &&
    $stable(status_quadlet_count))
    else $error("queue status moved in test mode");
  a_mismatch_sticky: assert property (control_mismatch_flag &&
    !test_address_clear_set && !$past(test_address_clear_set) |=>
    control_mismatch_flag)
    else $error("mismatch flag dropped without clear");
  c_irq: cover property (receive_data_ready_irq);
  c_mismatch: cover property ($rose(control_mismatch_flag));
  c_test_access: cover property (memory_test_enable && hit);
endmodule
bind rqr_queue rqr_queue_asserts rqr_queue_asserts_inst (.sys_clk, .rst_n,
  .host_sel, .host_addr, .host_ack, .memory_test_enable,
  .test_address_clear_set, .test_addr_load, .test_addr_value,
  .receive_data_ready_irq, .status_quadlet_count, .queue_used_count,
  .control_mismatch_flag, .test_address_clear_alias, .test_addr_count);

// [testbench/rqr_host_model.sv]
// Purpose: Host bus master that moves one quadlet per access.
// Assumes: Requests launch at the falling edge, taken at the rising one.
// Notes: A released bus shows inverted address and data, never the last ones.
module rqr_host_model (
  input wire logic sys_clk,
  output logic host_sel,
  output logic host_wr,
  output logic [7:0] host_addr,
  output logic [31:0] host_wdata,
  input wire logic [31:0] host_rdata,
  input wire logic host_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    host_sel = 1'b0;
    host_wr = 1'b0;
    host_addr = 8'h3f;
    host_wdata = 32'h0;
  end
  // One access at the data port; the answer is taken a cycle later.
  task automatic xfer(input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    @(negedge sys_clk);
    host_sel = 1'b1;
    host_wr = wr;
    host_addr = rqr_pkg::RQR_DATA_ADDR;
    host_wdata = wd;
    @(negedge sys_clk);
    ok = host_ack;
    rd = host_rdata;
    host_sel = 1'b0;
    host_addr = ~host_addr;
    host_wdata = ~wd;
  endtask
endmodule

// [testbench/rqr_queue_tb.sv]
// Purpose: Self-checking bench of the receive queue read port.
// Assumes: Inputs change at the falling edge of a 100 MHz clock.
// Notes: Transmit regions are 16 entries each, so the queue starts at 32.
module rqr_queue_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, host_sel, host_wr, host_ack, rx_valid, rx_ready;
  logic [7:0] host_addr, trigger_size;
  logic [31:0] host_wdata, host_rdata;
  rqr_pkg::rqr_item_t rx_item;
  rqr_pkg::rqr_pkt_info_t inf;
  logic snoop_enable, block_trigger_enable, bad_header_receive_option;
  logic [8:0] async_queue_size, iso_queue_size, test_addr_value;
  logic memory_test_enable, test_control_value, test_address_clear_set;
  logic test_addr_load, receive_data_ready_irq, token_at_head_flag;
  logic packet_complete_flag, control_mismatch_flag, test_address_clear_alias;
  logic [8:0] status_quadlet_count, test_addr_count;
  logic [9:0] queue_used_count;
  int num_errors = 0;
  int samples_checked = 0;
  int irq_cnt = 0;
  rqr_queue rqr_queue_inst (.sys_clk, .rst_n, .host_sel, .host_wr,
    .host_addr, .host_wdata, .host_rdata, .host_ack, .rx_valid, .rx_ready,
    .rx_item, .snoop_enable, .block_trigger_enable,
    .bad_header_receive_option, .trigger_size, .async_queue_size,
    .iso_queue_size, .memory_test_enable, .test_control_value,
    .test_address_clear_set, .test_addr_load, .test_addr_value,
    .receive_data_ready_irq, .token_at_head_flag, .packet_complete_flag,
    .status_quadlet_count, .queue_used_count, .control_mismatch_flag,
    .test_address_clear_alias, .test_addr_count);
  rqr_host_model rqr_host_model_inst (.sys_clk, .host_sel, .host_wr,
    .host_addr, .host_wdata, .host_rdata, .host_ack);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Counts data ready events so each scenario can judge their number.
  always @(posedge sys_clk) if (receive_data_ready_irq === 1'b1) irq_cnt++;
  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] tok(input logic [3:0] asn,
    input logic snp, pac, input logic [1:0] spd, input logic [8:0] cnt,
    input logic [3:0] tc, ak);
    return {7'h0, asn, pac, snp, spd, cnt, tc, ak};
  endfunction
  task automatic xf(input logic wr, input logic [31:0] wd, e, m,
                    input string nm);
    logic [31:0] d;
    logic ok;
    rqr_host_model_inst.xfer(wr, wd, d, ok);
    chk("host_ack", 32'h1, 32'(ok));
    if (!wr) chk(nm, e, d & m);
  endtask
  task automatic rd_data(input int first, n);
    for (int i = 0; i < n; i++) xf(1'b0, 0, 32'hd000_0000 + 32'(first + i),
      '1, "data");
  endtask
  // Sends one packet, holding each quadlet until the queue takes it.
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      rx_item = '{info: inf, last: (i == n - 1), data: 32'hd000_0000 + 32'(i)};
      rx_valid = 1'b1;
      while (rx_ready !== 1'b1) @(negedge sys_clk);
      @(posedge sys_clk);
    end
    @(negedge sys_clk);
    rx_valid = 1'b0;
    rx_item.data = ~rx_item.data;
  endtask
  // The host only reads once the event count shows a ready block.
  task automatic wait_irqs(input int want);
    for (int k = 0; k < 200 && irq_cnt < want; k++) @(negedge sys_clk);
    repeat (3) @(negedge sys_clk);
    chk("irq_count", 32'(want), 32'(irq_cnt));
  endtask
  task automatic pulse_clear;
    @(negedge sys_clk) test_address_clear_set = 1'b1;
    @(negedge sys_clk) test_address_clear_set = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic load_addr(input logic [8:0] a);
    @(negedge sys_clk) test_addr_value = a;
    test_addr_load = 1'b1;
    @(negedge sys_clk) test_addr_load = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  // A trigger size of five is still too small to split a packet.
  task automatic t_normal;
    block_trigger_enable = 1'b1;
    trigger_size = 8'h05;
    inf = '0;
    inf.tcode = 4'h7;
    inf.ack_sent = 4'h1;
    inf.receive_speed_code = rqr_pkg::RQR_SPD_400;
    send(7);
    wait_irqs(1);
    chk("head", 32'h1, 32'(token_at_head_flag));
    chk("count", 32'h7, 32'(status_quadlet_count));
    chk("pac", 32'h1, 32'(packet_complete_flag));
    chk("used", 32'h8, 32'(queue_used_count));
    xf(1'b0, 0, tok(0, 0, 1, 2, 7, 7, 1), '1, "token");
    rd_data(0, 7);
    xf(1'b0, 0, 32'h0, '1, "empty");
    repeat (3) @(negedge sys_clk);
    chk("used", 32'h0, 32'(queue_used_count));
    chk("head", 32'h0, 32'(token_at_head_flag));
  endtask
  // Special packets carry the forced code and are never split.
  task automatic t_special;
    snoop_enable = 1'b1;
    trigger_size = 8'h06;
    inf = '0;
    inf.snooped_ack_code = 4'h5;
    inf.special_pkt = 1'b1;
    inf.no_ack_pkt = 1'b1;
    inf.tcode = 4'h3;
    inf.ack_sent = 4'h3;
    send(8);
    wait_irqs(2);
    xf(1'b0, 0, tok(5, 1, 1, 0, 8, 4'he, 0), '1, "token");
    rd_data(0, 8);
    snoop_enable = 1'b0;
  endtask
  // Eight quadlets with size six give a block of six and one of two.
  task automatic t_split;
    inf = '0;
    inf.tcode = 4'h1;
    inf.ack_sent = 4'h1;
    inf.receive_speed_code = rqr_pkg::RQR_SPD_200;
    send(8);
    wait_irqs(4);
    xf(1'b0, 0, tok(0, 0, 0, 1, 6, 1, 0), 32'hffff_fff0, "token");
    rd_data(0, 6);
    xf(1'b0, 0, tok(0, 0, 1, 1, 2, 1, 1), '1, "token");
    rd_data(6, 2);
  endtask
  // Entries used so far place the pending token at 32 + 27.
  task automatic t_ram;
    block_trigger_enable = 1'b0;
    inf = '0;
    inf.tcode = 4'ha;
    inf.ack_sent = 4'h2;
    send(2);
    wait_irqs(5);
    memory_test_enable = 1'b1;
    pulse_clear;
    chk("taddr", 32'h0, 32'(test_addr_count));
    test_control_value = 1'b1;
    xf(1'b1, 32'h1111_1111, 0, 0, "wr");
    xf(1'b1, 32'h2222_2222, 0, 0, "wr");
    chk("taddr", 32'h2, 32'(test_addr_count));
    load_addr(9'h0);
    chk("head", 32'h1, 32'(token_at_head_flag));
    xf(1'b0, 0, 32'h1111_1111, '1, "ram");
    test_control_value = 1'b0;
    xf(1'b0, 0, 32'h2222_2222, '1, "ram");
    repeat (2) @(negedge sys_clk);
    chk("mismatch", 32'h1, 32'(control_mismatch_flag));
    load_addr(9'd59);
    chk("head", 32'h1, 32'(token_at_head_flag));
    xf(1'b0, 0, tok(0, 0, 1, 0, 2, 4'ha, 2), '1, "token");
    chk("used", 32'h3, 32'(queue_used_count));
    pulse_clear;
    chk("mismatch", 32'h0, 32'(control_mismatch_flag));
    chk("taddr", 32'h0, 32'(test_addr_count));
    memory_test_enable = 1'b0;
    repeat (3) @(negedge sys_clk);
    xf(1'b0, 0, tok(0, 0, 1, 0, 2, 4'ha, 2), '1, "token");
    rd_data(0, 2);
  endtask
  // A bad header option, then a quadlet packet, keep seven in one block.
  task automatic t_whole;
    block_trigger_enable = 1'b1;
    bad_header_receive_option = 1'b1;
    inf = '0;
    for (int j = 6; j < 8; j++) begin
      send(7);
      wait_irqs(j);
      xf(1'b0, 0, tok(0, 0, 1, 0, 7, 0, 0), '1, "token");
      rd_data(0, 7);
      bad_header_receive_option = 1'b0;
      inf.no_split_pkt = 1'b1;
    end
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    print_verdict;
  end
  initial begin
    {rst_n, rx_valid, snoop_enable, bad_header_receive_option} = 4'h0;
    {memory_test_enable, test_control_value, test_address_clear_set} = 3'h0;
    {block_trigger_enable, test_addr_load} = 2'h0;
    rx_item = '0;
    inf = '0;
    trigger_size = 8'h0;
    test_addr_value = 9'h0;
    async_queue_size = 9'h010;
    iso_queue_size = 9'h010;
    repeat (10) @(negedge sys_clk);
    rst_n = 1'b1;
    t_normal;
    t_special;
    t_split;
    t_ram;
    t_whole;
    print_verdict;
  end
endmodule
